/* loc_top.v */
// Logic output conditioner: two outputs with AXI4-Lite configuration.
// Assumes synchronous inputs, 50 MHz clock, card presence from the board.
// Notes on behaviour
// - An output follows a rising source only after the turn-on delay, 0 to 60000 ms, default 0.
// - The turn-on delay is zero and unwritable for no-fault, output, precharge and line contactor sources.
// - An output follows a falling source only after the holding time, 0 to 9999 ms, default 0.
// - The holding time is zero and unwritable for no-fault, precharge and line contactor sources.
// - Polarity picks the output level for a true source, positive by default.
// - Polarity stays positive for no-fault, precharge and line contactor sources.
// - The selector defaults to unassigned and also offers the contactor and damper sources.
// - Configuration is reachable only while the expansion card is present.
//
// Decided for this implementation: the register addresses and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`include "loc_consts.vh"
module loc_top (
  input wire clock_in,
  input wire rst_b_in,
  input wire card_present_in,
  input wire [31:0] src_vec_in,
  input wire [4:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [4:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  output reg logic_out_one_out,
  output reg logic_out_two_out
);
  // ----------------------------------------
  // Millisecond tick
  // ----------------------------------------
  // Free-running divider: the tick phase is unrelated to source edges,
  // so every delay and hold can run up to one tick shorter than set
  reg [15:0] div_q;
  reg tick_q;
  always @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      div_q <= 16'h0000;
      tick_q <= 1'b0;
    end else if (div_q == `LOC_TICK_LAST) begin
      div_q <= 16'h0000;
      tick_q <= 1'b1;
    end else begin
      div_q <= div_q + 16'h0001;
      tick_q <= 1'b0;
    end
  end
  // ----------------------------------------
  // Settings
  // ----------------------------------------
  reg [4:0] src_q [0:1];
  reg pol_q [0:1];
  reg [15:0] dly_q [0:1];
  reg [13:0] hld_q [0:1];
  reg [4:0] awaddr_q;
  reg [31:0] wdata_q;
  reg [3:0] wstrb_q;
  reg aw_got_q;
  reg w_got_q;
  wire do_wr;
  // Settings change one cycle after both halves are held, at the edge that raises bvalid
  assign do_wr = aw_got_q && w_got_q && !s_axi_bvalid;
  wire [1:0] chan_sts;
  // ----------------------------------------
  // Per-channel settings, locking and conditioning
  // ----------------------------------------
  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1) begin : ch
      // Timing writes are judged against the source already selected
      wire [4:0] s = src_q[g];
      wire lock_ph = (s == `LOC_SRC_NOFLT) || (s == `LOC_SRC_PRE) || (s == `LOC_SRC_LINE);
      wire lock_d = lock_ph || (s == `LOC_SRC_OUTC);
      wire sel = (awaddr_q[4:3] == g) && !awaddr_q[4];
      wire [4:0] ns = wdata_q[4:0];
      wire nlock_ph = (ns == `LOC_SRC_NOFLT) || (ns == `LOC_SRC_PRE) || (ns == `LOC_SRC_LINE);
      wire nlock_d = nlock_ph || (ns == `LOC_SRC_OUTC);
      always @(posedge clock_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
          src_q[g] <= `LOC_RST_SRC;
          pol_q[g] <= `LOC_RST_POL;
          dly_q[g] <= `LOC_RST_DLY;
          hld_q[g] <= `LOC_RST_HLD;
        end else if (do_wr && card_present_in && sel) begin
          if (!awaddr_q[2]) begin
            if (wstrb_q[0]) begin
              src_q[g] <= ns;
              if (nlock_d) dly_q[g] <= 16'h0000;
              if (nlock_ph) begin
                hld_q[g] <= 14'h0000;
                pol_q[g] <= 1'b0;
              end
            end
            // A source written in the same word decides the lock, else the present one
            if (wstrb_q[1] && !(wstrb_q[0] ? nlock_ph : lock_ph)) begin
              pol_q[g] <= wdata_q[`LOC_POL_BIT];
            end
          end else begin
            if (wstrb_q[1:0] == 2'b11 && !lock_d)
              dly_q[g] <= (wdata_q[15:0] > `LOC_DLY_MAX) ? `LOC_DLY_MAX : wdata_q[15:0];
            if (wstrb_q[3:2] == 2'b11 && !lock_ph)
              hld_q[g] <= (wdata_q[29:16] > {2'b00, `LOC_HLD_MAX}) ? `LOC_HLD_MAX : wdata_q[29:16];
          end
        end
      end
      // ----------------------------------------
      // Conditioning and output stage
      // ----------------------------------------
      wire lvl;
      loc_channel loc_channel_inst (
        .clock_in(clock_in),
        .rst_b_in(rst_b_in),
        .tick_in(tick_q),
        .src_in((s != `LOC_SRC_NONE) && src_vec_in[s]),
        .dly_in(dly_q[g]),
        .hld_in(hld_q[g]),
        .pol_neg_in(pol_q[g]),
        .state_out(chan_sts[g]),
        .level_out(lvl)
      );
      // Outputs stay inactive while the card is absent
      if (g == 0) begin : o0
        always @(posedge clock_in or negedge rst_b_in) begin
          if (!rst_b_in) logic_out_one_out <= 1'b0;
          else logic_out_one_out <= card_present_in & lvl;
        end
      end else begin : o1
        always @(posedge clock_in or negedge rst_b_in) begin
          if (!rst_b_in) logic_out_two_out <= 1'b0;
          else logic_out_two_out <= card_present_in & lvl;
        end
      end
    end
  endgenerate
  // ----------------------------------------
  // AXI4-Lite write
  // ----------------------------------------
  // Readies drop at each take and return after the response, so one write is in flight
  wire wr_hit = (awaddr_q <= `LOC_OFF_TIM1) && (awaddr_q[1:0] == 2'b00);
  always @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
      aw_got_q <= 1'b0;
      w_got_q <= 1'b0;
      awaddr_q <= 5'h00;
      wdata_q <= 32'h00000000;
      wstrb_q <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awaddr_q <= s_axi_awaddr;
        aw_got_q <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
        w_got_q <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      if (do_wr) begin
        s_axi_bvalid <= 1'b1;
        // Absent card or unmapped address gives SLVERR
        s_axi_bresp <= (wr_hit && card_present_in) ? 2'h0 : 2'h2;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        aw_got_q <= 1'b0;
        w_got_q <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end
  // ----------------------------------------
  // AXI4-Lite read
  // ----------------------------------------
  // Read data is registered at the address take; rvalid rises at that same edge
  reg [31:0] rd_d;
  reg rd_ok;
  always @* begin
    rd_d = 32'h00000000;
    rd_ok = card_present_in;
    case (s_axi_araddr)
      `LOC_OFF_CFG0: rd_d = {23'h000000, pol_q[0], 3'h0, src_q[0]};
      `LOC_OFF_TIM0: rd_d = {2'h0, hld_q[0], dly_q[0]};
      `LOC_OFF_CFG1: rd_d = {23'h000000, pol_q[1], 3'h0, src_q[1]};
      `LOC_OFF_TIM1: rd_d = {2'h0, hld_q[1], dly_q[1]};
      `LOC_OFF_STAT: begin
        rd_d = {29'h00000000, card_present_in, chan_sts};
        rd_ok = 1'b1;
      end
      default: rd_ok = 1'b0;
    endcase
  end
  always @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= 2'h0;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_ok ? rd_d : 32'h00000000;
      s_axi_rresp <= rd_ok ? 2'h0 : 2'h2;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end
endmodule // loc_top

/* loc_consts.vh */
// Constants of the logic output conditioner: register map, fields, resets, timing.
// Assumes an AXI4-Lite slave with 32-bit data and byte addresses.
`ifndef LOC_CONSTS_VH
`define LOC_CONSTS_VH
// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define LOC_OFF_CFG0 5'h00
`define LOC_OFF_TIM0 5'h04
`define LOC_OFF_CFG1 5'h08
`define LOC_OFF_TIM1 5'h0C
`define LOC_OFF_STAT 5'h10
// ----------------------------------------
// Config fields: [4:0] source, [8] polarity negative
// ----------------------------------------
`define LOC_SRC_W 5
`define LOC_POL_BIT 8
// Timing word: [15:0] turn-on delay ms, [29:16] holding time ms
`define LOC_DLY_MAX 16'hEA60
`define LOC_HLD_MAX 14'h270F
// ----------------------------------------
// Source codes
// ----------------------------------------
`define LOC_SRC_NONE 5'h00
`define LOC_SRC_NOFLT 5'h01
`define LOC_SRC_LINE 5'h1C
`define LOC_SRC_OUTC 5'h1D
`define LOC_SRC_PRE 5'h1E
`define LOC_SRC_DAMP 5'h1F
// ----------------------------------------
// Reset values and tick
// ----------------------------------------
`define LOC_RST_SRC 5'h00
`define LOC_RST_POL 1'b0
`define LOC_RST_DLY 16'h0000
`define LOC_RST_HLD 14'h0000
`define LOC_CLK_HZ 50000000
`define LOC_TICK_HZ 1000
`define LOC_TICK_CYC (`LOC_CLK_HZ / `LOC_TICK_HZ)
// Last divider count, one below the tick period in clocks
`define LOC_TICK_LAST 16'hC34F
`endif

/* loc_channel.v */
// One conditioned output: delay on rise, hold on fall, polarity.
// Assumes a one-cycle 1 ms tick and settings already forced by the caller.
`timescale 1ns/1ps
module loc_channel (
  input wire clock_in,
  input wire rst_b_in,
  input wire tick_in,
  input wire src_in,
  input wire [15:0] dly_in,
  input wire [13:0] hld_in,
  input wire pol_neg_in,
  output reg state_out,
  output reg level_out
);
  reg [15:0] cnt_q;
  wire [15:0] limit;
  assign limit = state_out ? {2'b00, hld_in} : dly_in;
  always @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      cnt_q <= 16'h0000;
      state_out <= 1'b0;
      level_out <= 1'b0;
    end else begin
      level_out <= state_out ^ pol_neg_in;
      if (src_in == state_out) begin
        // Source back at the present state: restart so short pulses are ignored
        cnt_q <= 16'h0000;
      end else if (cnt_q >= limit) begin
        state_out <= src_in;
        cnt_q <= 16'h0000;
      end else if (tick_in) begin
        cnt_q <= cnt_q + 16'h0001;
      end
    end
  end
endmodule // loc_channel

/* loc_top_chk.sv */
// Checker for loc_top: bus timing and card gating.
// Assumes binding to loc_top and sees its ports only.
`timescale 1ns/1ps
module loc_top_chk (
  input wire clock_in,
  input wire rst_b_in,
  input wire card_present_in,
  input wire [4:0] s_axi_araddr,
  input wire s_axi_awvalid,
  input wire s_axi_awready,
  input wire s_axi_wvalid,
  input wire s_axi_wready,
  input wire [1:0] s_axi_bresp,
  input wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire [1:0] s_axi_rresp,
  input wire s_axi_rvalid,
  input wire logic_out_one_out,
  input wire logic_out_two_out
);
  default clocking @(posedge clock_in); endclocking
  default disable iff (!rst_b_in);
  sequence s_wtake;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_rtake;
    s_axi_arvalid && s_axi_arready;
  endsequence
  AST_B_LAT: assert property (s_wtake |=> !s_axi_bvalid ##1 s_axi_bvalid) else $error("write response late");
  AST_R_LAT: assert property (s_rtake |=> s_axi_rvalid) else $error("read response late");
  AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  AST_B_DONE: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid && s_axi_awready)
    else $error("write not released");
  AST_AW_BUSY: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready) else $error("write taken early");
  AST_AR_BUSY: assert property (s_axi_rvalid |-> !s_axi_arready) else $error("read taken early");
  AST_CARD: assert property (!card_present_in [*3] |-> !logic_out_one_out && !logic_out_two_out)
    else $error("output live without card");
  AST_RD_ABSENT: assert property (s_axi_arvalid && s_axi_arready && !card_present_in && s_axi_araddr < 5'h10
    |=> s_axi_rresp == 2'b10 && s_axi_rdata == 32'h0) else $error("config readable without card");
  AST_UNMAP: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr > 5'h10 |=> s_axi_rresp == 2'b10)
    else $error("unmapped read accepted");
endmodule // loc_top_chk
bind loc_top loc_top_chk loc_top_chk_inst (.*);

/* logic_output_conditioner_tb.sv */
// Testbench for loc_top: registers, locking, delay, polarity, card gating.
// Assumes the 1 ms tick is 50000 cycles; one 1 ms delay and one 1 ms hold run to expiry.
`timescale 1ns/1ps
`include "loc_consts.vh"
module logic_output_conditioner_tb;
  reg clock_in = 1'b0;
  reg rst_b_in = 1'b0;
  reg card_present_in = 1'b1;
  reg [31:0] src_vec_in = 32'h0;
  reg [4:0] s_axi_awaddr = 5'h00;
  reg [4:0] s_axi_araddr = 5'h00;
  reg [31:0] s_axi_wdata = 32'h0;
  reg [3:0] s_axi_wstrb = 4'hF;
  reg s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, logic_out_one_out, logic_out_two_out;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  integer bad_count = 0, checks = 0, cyc = 0;
  reg [31:0] d;
  reg [1:0] r;
  loc_top loc_top_inst (.*);
  always #10 clock_in = ~clock_in;
  task final_report;
    $display("checks=%0d bad_count=%0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // Cuts a hang short; the tests need a little over one tick period
  always @(posedge clock_in) begin
    cyc = cyc + 1;
    if (cyc == 60000) begin
      bad_count = bad_count + 1;
      final_report;
    end
  end
  task chk(input [31:0] seen, input [31:0] exp);
    checks = checks + 1;
    if (seen !== exp) begin
      bad_count = bad_count + 1;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task wr(input [4:0] a, input [31:0] v);
    @(posedge clock_in);
    s_axi_awaddr <= a; s_axi_wdata <= v; s_axi_awvalid <= 1'b1; s_axi_wvalid <= 1'b1; s_axi_bready <= 1'b1;
    do begin
      @(posedge clock_in);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task rd(input [4:0] a);
    @(posedge clock_in);
    s_axi_araddr <= a; s_axi_arvalid <= 1'b1; s_axi_rready <= 1'b1;
    do begin
      @(posedge clock_in);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  task t_reset;
    rd(`LOC_OFF_CFG0); chk(d, 32'h0);
    rd(`LOC_OFF_TIM0); chk(d, 32'h0);
    rd(`LOC_OFF_STAT); chk(d, 32'h4);
    $display("reset values done");
  endtask
  task t_lock;
    wr(`LOC_OFF_CFG1, 32'h11E); chk({30'h0, r}, 32'h0);
    rd(`LOC_OFF_CFG1); chk(d, 32'h1E);
    wr(`LOC_OFF_TIM1, 32'h70005); rd(`LOC_OFF_TIM1); chk(d, 32'h0);
    wr(`LOC_OFF_CFG1, 32'h11D); rd(`LOC_OFF_CFG1); chk(d, 32'h11D);
    wr(`LOC_OFF_TIM1, 32'h70005);
    rd(`LOC_OFF_TIM1); chk(d, 32'h70000);
    wr(`LOC_OFF_CFG1, 32'h1F); wr(`LOC_OFF_TIM1, 32'hFFFFFFFF);
    rd(`LOC_OFF_TIM1); chk(d, 32'h270FEA60);
    $display("locking done");
  endtask
  task t_delay;
    wr(`LOC_OFF_CFG0, 32'h3); wr(`LOC_OFF_TIM0, 32'h1); wr(`LOC_OFF_TIM1, 32'h10000);
    src_vec_in <= 32'h80000000;
    repeat (6) @(posedge clock_in);
    chk({31'h0, logic_out_two_out}, 32'h1);
    src_vec_in <= 32'h8;
    repeat (300) @(posedge clock_in);
    chk({31'h0, logic_out_one_out}, 32'h0);
    chk({31'h0, logic_out_two_out}, 32'h1);
    // One tick period covers any tick phase, so both timers have run out here
    repeat (50000) @(posedge clock_in);
    chk({31'h0, logic_out_one_out}, 32'h1);
    chk({31'h0, logic_out_two_out}, 32'h0);
    wr(`LOC_OFF_TIM0, 32'h0);
    $display("delay done");
  endtask
  task t_pol;
    wr(`LOC_OFF_CFG0, 32'h102); src_vec_in <= 32'h0;
    repeat (6) @(posedge clock_in);
    chk({31'h0, logic_out_one_out}, 32'h1);
    src_vec_in <= 32'h4;
    repeat (6) @(posedge clock_in);
    chk({31'h0, logic_out_one_out}, 32'h0);
    $display("polarity done");
  endtask
  task t_card;
    src_vec_in <= 32'h0; card_present_in <= 1'b0;
    repeat (6) @(posedge clock_in);
    chk({31'h0, logic_out_one_out}, 32'h0);
    rd(`LOC_OFF_CFG0); chk(d, 32'h0); chk({30'h0, r}, 32'h2);
    wr(`LOC_OFF_CFG0, 32'h0); chk({30'h0, r}, 32'h2);
    card_present_in <= 1'b1;
    rd(`LOC_OFF_CFG0); chk(d, 32'h102);
    rd(5'h14); chk({30'h0, r}, 32'h2);
    $display("card done");
  endtask
  initial begin
    repeat (3) @(posedge clock_in);
    rst_b_in <= 1'b1;
    t_reset;
    t_lock;
    t_delay;
    t_pol;
    t_card;
    final_report;
  end
endmodule // logic_output_conditioner_tb
